// ==== hdl/core_regs_map.vh ====
// register offsets, reset values and field positions of the core group
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH

// register offsets on the internal register bus
`define ADDR_STACK_POINTER     8'h81
`define ADDR_POINTER_LOW_BYTE  8'h82
`define ADDR_POINTER_HIGH_BYTE 8'h83
`define ADDR_POWER_CONTROL     8'h87
`define ADDR_PROGRAM_STATUS    8'hD0
`define ADDR_MAIN_OPERAND      8'hE0
`define ADDR_SECOND_OPERAND    8'hF0

// reset values
`define RST_STACK_POINTER      8'h07
`define RST_BYTE_ZERO          8'h00
`define RST_POINTER            16'h0000

// program status field positions
`define PS_CARRY               7
`define PS_HALF_CARRY          6
`define PS_USER_ZERO           5
`define PS_BANK_HIGH           4
`define PS_BANK_LOW            3
`define PS_SIGNED_EXCESS       2
`define PS_USER_ONE            1
`define PS_PARITY              0

// power control field positions
`define PC_STOP                1
`define PC_IDLE                0

// bit addressing: low nibble of offset that allows single-bit access
`define BIT_ADDR_NIBBLE_A      4'h0
`define BIT_ADDR_NIBBLE_B      4'h8

// timing
`define CLK_MHZ                125
`define MCD_TIMEOUT_US         100
`define WDT_TIMEOUT_CYCLES     65536

`endif

// ==== hdl/timeout_counter.v ====
// self-restarting timeout counter with run, clear and registered expiry pulse
`timescale 1ns/1ns

module timeout_counter #(
  parameter WIDTH = 17,          // counter width
  parameter LIMIT = 65536        // cycles to expiry
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             sys_rst,
  // control
  input  wire             run,
  input  wire             clear,
  // status
  output reg              expired_q
);

  localparam [31:0]      LIMIT_M1 = LIMIT - 1;           // last count, full
  localparam [WIDTH-1:0] LAST     = LIMIT_M1[WIDTH-1:0]; // terminal count
  localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

  reg [WIDTH-1:0] count_q;                   // elapsed cycles

  // count while running, restart on clear or at expiry
  always @(posedge sys_clk) begin
    if (sys_rst || clear) begin
      count_q   <= ZERO;
      expired_q <= 1'b0;
    end else if (run) begin
      if (count_q == LAST) begin
        count_q   <= ZERO;
        expired_q <= 1'b1;
      end else begin
        count_q   <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        expired_q <= 1'b0;
      end
    end else begin
      expired_q <= 1'b0;
    end
  end

endmodule

// ==== hdl/core_status_power_regs.v ====
// core stack, pointer, status, operand and power control registers
`timescale 1ns/1ns
`include "core_regs_map.vh"

// Behaviour
// - stack pointer resets seven, increments before push
// - two pointer bytes form sixteen-bit data pointer
// - carry set on carry or borrow
// - half carry set on nibble carry or borrow
// - two user flags are software only
// - bank field selects eight-byte register bank
// - signed excess set on overflow conditions
// - signed excess cleared otherwise by those ops
// - parity bit mirrors main operand odd parity
// - idle write halts cpu after instruction
// - idle preserves all register contents
// - enabled interrupt ends idle and resumes
// - any reset ends idle or stop, restarts
// - watchdog keeps counting in idle, may reset
// - stop write halts oscillator, cpu, peripherals
// - only reset ends stop, never interrupts
// - clock detector active in stop, resets
// - power select bits trigger, read zero
// - bit access only at offsets ending 0/8
module core_status_power_regs #(
  parameter MCD_CYCLES = `MCD_TIMEOUT_US * `CLK_MHZ, // detector timeout
  parameter WDT_CYCLES = `WDT_TIMEOUT_CYCLES         // watchdog timeout
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // register bus
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        reg_bit,
  input  wire [2:0]  reg_bit_sel,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  output reg         reg_ack_q,
  // cpu execution side
  input  wire        push_op,
  input  wire        pop_op,
  input  wire        pointer_inc,
  input  wire        operand_we,
  input  wire [7:0]  operand_wdata,
  input  wire        second_we,
  input  wire [7:0]  second_wdata,
  input  wire        arith_op,
  input  wire        arith_carry,
  input  wire        arith_half_carry,
  input  wire        excess_op,
  input  wire        excess_cond,
  input  wire        instr_done,
  // interrupt and reset side
  input  wire        irq_enabled_pending,
  input  wire        ext_rst_pin,
  input  wire        watchdog_enable,
  input  wire        watchdog_kick,
  input  wire        clock_detect_enable,
  input  wire        osc_alive,
  // register values to the core
  output reg  [7:0]  stack_pointer_q,
  output reg  [15:0] data_pointer_q,
  output reg  [7:0]  program_status_q,
  output reg  [7:0]  main_operand_q,
  output reg  [7:0]  second_operand_q,
  output reg  [4:0]  bank_base_q,
  // power state to the core
  output reg         cpu_halt_q,
  output reg         periph_stop_q,
  output reg         int_osc_stop_q,
  output reg         idle_wake_q,
  output reg         core_reset_q
);

  // power states, one-hot
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  // synchroniser for the external reset pin
  reg        ext_rst_meta_q;              // first stage, read only by next
  reg        ext_rst_sync_q;              // second stage
  // power state and pending requests
  reg [2:0]  pstate_q;
  reg [2:0]  pstate_d;
  reg        idle_req_q;                  // idle written, await instr end
  reg        stop_req_q;                  // stop written, await instr end
  // internal reset sources
  wire       wdt_expired;
  wire       mcd_expired;
  wire       any_reset;                   // resets all register state
  // decoded bus strobes
  wire       bit_ok;                      // offset allows single bits
  wire       wr_ok;                       // accepted write
  wire       wr_sp;
  wire       wr_dpl;
  wire       wr_dph;
  wire       wr_power_control;
  wire       wr_psw;
  wire       wr_acc;
  wire       wr_b;
  wire [7:0] bit_mask;                    // one-hot lane for bit writes
  // next values
  reg  [7:0] sp_d;
  reg  [15:0] data_pointer_d;
  reg  [7:0] psw_d;
  reg  [7:0] acc_d;
  reg  [7:0] b_d;
  reg  [7:0] rdata_d;
  reg        hit_d;

  // two-flop synchroniser on the asynchronous reset pin
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_rst_meta_q <= 1'b0;
      ext_rst_sync_q <= 1'b0;
    end else begin
      ext_rst_meta_q <= ext_rst_pin;
      ext_rst_sync_q <= ext_rst_meta_q;
    end
  end

  // watchdog keeps counting through idle, frozen in stop
  timeout_counter #(
    .WIDTH (32),
    .LIMIT (WDT_CYCLES)
  ) u_watchdog (
    .sys_clk   (sys_clk),
    .sys_rst   (any_reset),
    .run       (watchdog_enable && (pstate_q != ST_STOP)),
    .clear     (watchdog_kick || !watchdog_enable),
    .expired_q (wdt_expired)
  );

  // missing clock detector counts silence of the oscillator, even in stop
  timeout_counter #(
    .WIDTH (32),
    .LIMIT (MCD_CYCLES)
  ) u_missing_clock_detector (
    .sys_clk   (sys_clk),
    .sys_rst   (any_reset),
    .run       (clock_detect_enable && !osc_alive),
    .clear     (osc_alive || !clock_detect_enable),
    .expired_q (mcd_expired)
  );

  // every reset source restarts the whole group
  assign any_reset = sys_rst || core_reset_q;

  // single-bit access only on offsets ending in 0 or 8
  assign bit_ok = (reg_addr[3:0] == `BIT_ADDR_NIBBLE_A) ||
                  (reg_addr[3:0] == `BIT_ADDR_NIBBLE_B);
  assign wr_ok  = reg_wr && (!reg_bit || bit_ok);
  assign wr_sp   = wr_ok && (reg_addr == `ADDR_STACK_POINTER);
  assign wr_dpl  = wr_ok && (reg_addr == `ADDR_POINTER_LOW_BYTE);
  assign wr_dph  = wr_ok && (reg_addr == `ADDR_POINTER_HIGH_BYTE);
  assign wr_power_control = wr_ok && (reg_addr == `ADDR_POWER_CONTROL);
  assign wr_psw  = wr_ok && (reg_addr == `ADDR_PROGRAM_STATUS);
  assign wr_acc  = wr_ok && (reg_addr == `ADDR_MAIN_OPERAND);
  assign wr_b    = wr_ok && (reg_addr == `ADDR_SECOND_OPERAND);
  assign bit_mask = 8'h01 << reg_bit_sel;

  // merge a bus write into an old byte, whole or one bit
  function [7:0] merge;
    input [7:0] old;
    input       is_bit;
    input [7:0] mask;
    input [7:0] wdata;
    begin
      if (is_bit)
        merge = wdata[0] ? (old | mask) : (old & ~mask);
      else
        merge = wdata;
    end
  endfunction

  // stack pointer: push pre-increments, pop post-decrements
  always @* begin
    sp_d = stack_pointer_q;
    if (wr_sp) begin
      sp_d = reg_wdata;
    end else if (push_op) begin
      sp_d = stack_pointer_q + 8'h01;
    end else if (pop_op) begin
      sp_d = stack_pointer_q - 8'h01;
    end
  end

  // data pointer: two byte halves, hardware increment as one word
  always @* begin
    data_pointer_d = data_pointer_q;
    if (pointer_inc) begin
      data_pointer_d = data_pointer_q + 16'h0001;
    end
    if (wr_dpl) begin
      data_pointer_d[7:0] = reg_wdata;
    end
    if (wr_dph) begin
      data_pointer_d[15:8] = reg_wdata;
    end
  end

  // operand registers: cpu load, bus write wins
  always @* begin
    acc_d = main_operand_q;
    b_d   = second_operand_q;
    if (operand_we) begin
      acc_d = operand_wdata;
    end
    if (second_we) begin
      b_d = second_wdata;
    end
    if (wr_acc) begin
      acc_d = merge(main_operand_q, reg_bit, bit_mask, reg_wdata);
    end
    if (wr_b) begin
      b_d = merge(second_operand_q, reg_bit, bit_mask, reg_wdata);
    end
  end

  // status flags: hardware updates first, then software overrides
  always @* begin
    psw_d = program_status_q;
    if (arith_op) begin
      psw_d[`PS_CARRY]      = arith_carry;
      psw_d[`PS_HALF_CARRY] = arith_half_carry;
    end
    if (excess_op) begin
      // set on overflow, cleared by the same ops otherwise
      psw_d[`PS_SIGNED_EXCESS] = excess_cond;
    end
    if (wr_psw) begin
      // user flags and bank field are touched only by this path
      psw_d = merge(program_status_q, reg_bit, bit_mask,
                    reg_wdata);
    end
    // parity is read-only and follows the next operand value
    psw_d[`PS_PARITY] = ^acc_d;
  end

  // register update; idle and stop leave contents untouched
  always @(posedge sys_clk) begin
    if (any_reset) begin
      stack_pointer_q  <= `RST_STACK_POINTER;
      data_pointer_q   <= `RST_POINTER;
      program_status_q <= `RST_BYTE_ZERO;
      main_operand_q   <= `RST_BYTE_ZERO;
      second_operand_q <= `RST_BYTE_ZERO;
      bank_base_q      <= 5'h00;
    end else begin
      stack_pointer_q  <= sp_d;
      data_pointer_q   <= data_pointer_d;
      program_status_q <= psw_d;
      main_operand_q   <= acc_d;
      second_operand_q <= b_d;
      // bank n covers data addresses 8n through 8n+7
      bank_base_q <= {psw_d[`PS_BANK_HIGH], psw_d[`PS_BANK_LOW],
                      3'b000};
    end
  end

  // power state next value
  always @* begin
    pstate_d = pstate_q;
    case (pstate_q)
      ST_RUN: begin
        // entry only once the writing instruction has finished
        if (instr_done && stop_req_q) begin
          pstate_d = ST_STOP;
        end else if (instr_done && idle_req_q) begin
          pstate_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // an enabled interrupt clears idle and resumes the cpu
        if (irq_enabled_pending) begin
          pstate_d = ST_RUN;
        end
      end
      ST_STOP: begin
        // interrupts are ignored, only a reset leaves stop
        pstate_d = ST_STOP;
      end
      default: begin
        pstate_d = ST_RUN;
      end
    endcase
  end

  // power state, write-one triggers and derived halt outputs
  always @(posedge sys_clk) begin
    if (any_reset) begin
      pstate_q       <= ST_RUN;
      idle_req_q     <= 1'b0;
      stop_req_q     <= 1'b0;
      cpu_halt_q     <= 1'b0;
      periph_stop_q  <= 1'b0;
      int_osc_stop_q <= 1'b0;
      idle_wake_q    <= 1'b0;
    end else begin
      pstate_q <= pstate_d;
      // triggers held only until the instruction ends
      if (wr_power_control && reg_wdata[`PC_STOP]) begin
        stop_req_q <= 1'b1;
      end else if (instr_done) begin
        stop_req_q <= 1'b0;
      end
      if (wr_power_control && reg_wdata[`PC_IDLE]) begin
        idle_req_q <= 1'b1;
      end else if (instr_done) begin
        idle_req_q <= 1'b0;
      end
      // cpu halted in idle and stop; clocks go only in stop
      cpu_halt_q     <= (pstate_d != ST_RUN);
      periph_stop_q  <= (pstate_d == ST_STOP);
      int_osc_stop_q <= (pstate_d == ST_STOP);
      // one-cycle pulse when an interrupt ends idle
      idle_wake_q <= (pstate_q == ST_IDLE) &&
                     (pstate_d == ST_RUN);
    end
  end

  // internal and external reset requests, merged into one registered pulse that clears itself the next cycle
  always @(posedge sys_clk) begin
    if (sys_rst || core_reset_q) begin
      core_reset_q <= 1'b0;
    end else begin
      core_reset_q <= ext_rst_sync_q || wdt_expired ||
                      mcd_expired;
    end
  end

  // read data mux; power select bits and reserved bits read zero
  always @* begin
    rdata_d = `RST_BYTE_ZERO;
    hit_d   = 1'b1;
    case (reg_addr)
      `ADDR_STACK_POINTER:     rdata_d = stack_pointer_q;
      `ADDR_POINTER_LOW_BYTE:  rdata_d = data_pointer_q[7:0];
      `ADDR_POINTER_HIGH_BYTE: rdata_d = data_pointer_q[15:8];
      `ADDR_POWER_CONTROL:     rdata_d = `RST_BYTE_ZERO;
      `ADDR_PROGRAM_STATUS:    rdata_d = program_status_q;
      `ADDR_MAIN_OPERAND:      rdata_d = main_operand_q;
      `ADDR_SECOND_OPERAND:    rdata_d = second_operand_q;
      default:                 hit_d   = 1'b0;
    endcase
    // refused bit reads answer nothing
    if (reg_bit && !bit_ok) begin
      hit_d = 1'b0;
    end
  end

  // registered read answer and acknowledge
  always @(posedge sys_clk) begin
    if (any_reset) begin
      reg_rdata_q <= `RST_BYTE_ZERO;
      reg_ack_q   <= 1'b0;
    end else begin
      reg_ack_q <= (reg_rd && hit_d) ||
                   (reg_wr && wr_ok && hit_d);
      if (reg_rd && hit_d) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule

// ==== test/cpu_model.sv ====
// behavioural cpu partner: completes one instruction every fourth cycle
`timescale 1ns/1ns

module cpu_model (
  // clock and reset
  input  wire sys_clk,
  input  wire sys_rst,
  // power state from the block
  input  wire cpu_halt_q,
  // instruction completion to the block
  output reg  instr_done = 1'b0
);
  reg [1:0] phase_q = 2'h0;  // position inside the current instruction

  // a halted core retires nothing, so completions stop while halted
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_q    <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      phase_q    <= phase_q + {1'b0, !cpu_halt_q};
      instr_done <= !cpu_halt_q && (phase_q == 2'h3);
    end
  end
endmodule

// ==== test/core_regs_chk_asserts.sv ====
// concurrent checks on the core register group ports
`timescale 1ns/1ns

module core_regs_chk #(
  parameter MCD_CYCLES = 20,  // detector timeout
  parameter WDT_CYCLES = 30   // watchdog timeout
) (
  // clock, reset and register bus
  input wire        sys_clk, sys_rst, reg_wr, reg_rd, reg_bit, reg_ack_q,
  input wire [7:0]  reg_addr, reg_wdata, reg_rdata_q,
  // cpu and power side
  input wire        push_op, pointer_inc, arith_op, arith_carry,
  input wire        arith_half_carry, excess_op, excess_cond, instr_done,
  input wire        ext_rst_pin, cpu_halt_q, periph_stop_q, int_osc_stop_q,
  input wire        idle_wake_q, core_reset_q,
  // register values
  input wire [7:0]  stack_pointer_q, program_status_q, main_operand_q,
  input wire [15:0] data_pointer_q,
  input wire [4:0]  bank_base_q
);
  reg rst_seen_q;  // a reset was applied at the last edge

  // attempts that start on the edge that applies a reset see stale values
  always @(posedge sys_clk) begin
    rst_seen_q <= sys_rst || core_reset_q;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || core_reset_q || rst_seen_q);

  // byte write to the stack pointer and its answer
  sequence s_sp_wr;
    reg_wr && !reg_bit && reg_addr == 8'h81;
  endsequence
  sequence s_sp_ans;
    reg_ack_q && stack_pointer_q == $past(reg_wdata);
  endsequence

  a_sp_push: assert property (push_op && !reg_wr && !cpu_halt_q |=>
    stack_pointer_q == $past(stack_pointer_q) + 8'h01)
    else $error("stack pointer did not step on push");
  a_dp_step: assert property (pointer_inc && !reg_wr |=>
    data_pointer_q == $past(data_pointer_q) + 16'h0001)
    else $error("data pointer did not step");
  a_carry_load: assert property (arith_op && !reg_wr |=>
    program_status_q[7:6] == $past({arith_carry, arith_half_carry}))
    else $error("carry flags not loaded");
  a_excess_load: assert property (excess_op && !reg_wr |=>
    program_status_q[2] == $past(excess_cond))
    else $error("signed excess flag not loaded");
  a_user_hold: assert property (!reg_wr |=>
    $stable(program_status_q[5]) && $stable(program_status_q[1]))
    else $error("user flag changed without write");
  a_bank_map: assert property (1'b1 |-> ##[0:1]
    bank_base_q == {program_status_q[4:3], 3'b000})
    else $error("bank base does not follow bank field");
  a_parity_live: assert property (
    program_status_q[0] == ^main_operand_q)
    else $error("parity bit wrong");
  a_halt_entry: assert property ($rose(cpu_halt_q) |->
    $past(instr_done))
    else $error("halt began before instruction end");
  a_wake_exit: assert property (idle_wake_q |->
    !cpu_halt_q && $past(cpu_halt_q))
    else $error("wake pulse without leaving halt");
  a_stop_hold: assert property (periph_stop_q |=> periph_stop_q)
    else $error("stop left without reset");
  a_stop_all: assert property (periph_stop_q |->
    int_osc_stop_q && cpu_halt_q)
    else $error("stop did not halt everything");
  a_pin_reset: assert property ($rose(ext_rst_pin) |->
    ##[1:4] core_reset_q)
    else $error("pin reset not passed on");
  a_power_zero: assert property (reg_rd && !reg_bit &&
    reg_addr == 8'h87 |=> reg_ack_q && reg_rdata_q == 8'h00)
    else $error("power control read not zero");
  a_bit_refuse: assert property ((reg_wr || reg_rd) && reg_bit &&
    reg_addr[2:0] != 3'h0 |=> !reg_ack_q)
    else $error("bit access accepted at byte-only offset");
  a_sw_wins: assert property (s_sp_wr |=> s_sp_ans)
    else $error("stack pointer write lost");
endmodule

bind core_status_power_regs core_regs_chk #(
  .MCD_CYCLES(MCD_CYCLES), .WDT_CYCLES(WDT_CYCLES)) chk (.*);

// ==== test/core_status_power_regs_tb.sv ====
// self-checking bench for the core register group
`timescale 1ns/1ns

module core_status_power_regs_tb;
  reg         sys_clk, sys_rst, reg_wr, reg_rd, reg_bit, irq, pin;
  reg  [7:0]  reg_addr, reg_wdata, opd, hold;  // bus and cpu data
  reg  [2:0]  reg_bit_sel;
  reg         push_op, ptr_inc, arith_op, cy, hc, ex_op, ex_c, opd_we;
  reg         pop_op, kick, b_we;    // pop, watchdog restart, second load
  reg  [7:0]  b_wd;                  // cpu data for the second operand
  reg         wd_en, cd_en, osc_ok;  // watchdog and detector controls
  wire [7:0]  rdata, sp, ps, mo, so; // read data and register values
  wire [15:0] dp;
  wire [4:0]  bank;
  wire        ack, halt, pstop, wake, crst, done, ostop;
  integer     miscompares, comparisons, i;
  reg  [31:0] row [0:6];             // offset, reset, write, readback

  // device under test with shortened timeouts
  core_status_power_regs #(.MCD_CYCLES(20), .WDT_CYCLES(30)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit(reg_bit),
    .reg_bit_sel(reg_bit_sel), .reg_wdata(reg_wdata),
    .reg_rdata_q(rdata), .reg_ack_q(ack), .push_op(push_op),
    .pop_op(pop_op), .pointer_inc(ptr_inc), .operand_we(opd_we),
    .operand_wdata(opd), .second_we(b_we), .second_wdata(b_wd),
    .arith_op(arith_op), .arith_carry(cy), .arith_half_carry(hc),
    .excess_op(ex_op), .excess_cond(ex_c), .instr_done(done),
    .irq_enabled_pending(irq), .ext_rst_pin(pin),
    .watchdog_enable(wd_en), .watchdog_kick(kick),
    .clock_detect_enable(cd_en), .osc_alive(osc_ok),
    .stack_pointer_q(sp), .data_pointer_q(dp), .program_status_q(ps),
    .main_operand_q(mo), .second_operand_q(so), .bank_base_q(bank),
    .cpu_halt_q(halt), .periph_stop_q(pstop), .int_osc_stop_q(ostop),
    .idle_wake_q(wake), .core_reset_q(crst));

  // far-side cpu partner
  cpu_model cpu (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cpu_halt_q(halt), .instr_done(done));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end

  // one-cycle bus access, answer sampled after the taking edge
  task acc(input w, input [7:0] a, input [7:0] d, input b,
           input [2:0] s);
    begin
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      reg_bit <= b;
      reg_bit_sel <= s;
      @(posedge sys_clk);
      {reg_wr, reg_rd, reg_bit} <= 3'b000;
      #1;
    end
  endtask

  // one-cycle cpu pulse: push, pointer, arith, excess, operand load
  task op(input [4:0] v, input [7:0] d);
    begin
      @(posedge sys_clk);
      {push_op, ptr_inc, arith_op, ex_op, opd_we} <= v;
      {cy, hc, ex_c} <= {d[7:6], d[2]};
      opd <= d;
      @(posedge sys_clk);
      {push_op, ptr_inc, arith_op, ex_op, opd_we} <= 5'h00;
      #1;
    end
  endtask

  // compare and count
  task chk(input [7:0] g, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask

  // verdict and end of run
  task tally_and_finish;
    begin
      $display("%0d miscompares in %0d comparisons", miscompares,
               comparisons);
      if (miscompares == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // bounded wait: 0 halt up, 1 halt down, 2 internal reset
  task wt(input [1:0] k);
    integer j;
    reg     hit;
    begin
      hit = 1'b0;
      for (j = 0; j < 300 && !hit; j = j + 1) begin
        @(posedge sys_clk);
        #1;
        hit = (k == 2'd0) ? halt === 1'b1 :
              (k == 2'd1) ? halt === 1'b0 : crst === 1'b1;
      end
      if (!hit) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: wait ran out", $time);
        tally_and_finish;
      end
    end
  endtask

  // main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    {reg_wr, reg_rd, reg_bit, irq, pin, push_op, ptr_inc} = 7'h00;
    {arith_op, cy, hc, ex_op, ex_c, opd_we, wd_en, cd_en} = 8'h00;
    {reg_addr, reg_wdata, opd, reg_bit_sel} = 27'h0;
    {pop_op, kick, b_we, b_wd} = 11'h000;
    osc_ok = 1'b1;
    sys_rst = 1'b1;
    row[0] = 32'h8107A5A5;
    row[1] = 32'h82003C3C;
    row[2] = 32'h8300C3C3;
    row[3] = 32'h87000000;
    row[4] = 32'hD0002222;
    row[5] = 32'hE0008181;
    row[6] = 32'hF0005A5A;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      acc(1'b0, row[i][31:24], 8'h00, 1'b0, 3'h0);
      chk(rdata, row[i][23:16]);
      acc(1'b1, row[i][31:24], row[i][15:8], 1'b0, 3'h0);
      acc(1'b0, row[i][31:24], 8'h00, 1'b0, 3'h0);
      chk(rdata, row[i][7:0]);
      chk({7'h00, ack}, 8'h01);
    end
    acc(1'b1, 8'h81, 8'h01, 1'b1, 3'h0);
    chk({7'h00, ack}, 8'h00);
    chk(sp, 8'hA5);
    acc(1'b1, 8'hD0, 8'h00, 1'b1, 3'h1);
    chk(ps, 8'h20);
    op(5'b10000, 8'h00);
    chk(sp, 8'hA6);
    // pop steps back while the cpu loads the second operand
    @(posedge sys_clk);
    {pop_op, b_we, b_wd} <= 10'h366;
    @(posedge sys_clk);
    {pop_op, b_we} <= 2'b00;
    #1;
    chk(sp, 8'hA5);
    chk(so, 8'h66);
    // bus write to the second operand beats a same-cycle cpu load
    fork
      acc(1'b1, 8'hF0, 8'h33, 1'b0, 3'h0);
      begin
        @(posedge sys_clk);
        {b_we, b_wd} <= 9'h199;
        @(posedge sys_clk);
        b_we <= 1'b0;
      end
    join
    chk(so, 8'h33);
    acc(1'b1, 8'h82, 8'hFF, 1'b0, 3'h0);
    op(5'b01000, 8'h00);
    chk(dp[15:8], 8'hC4);
    chk(dp[7:0], 8'h00);
    op(5'b00110, 8'hC4);
    chk({5'h00, ps[7:6], ps[2]}, 8'h07);
    op(5'b00110, 8'h00);
    chk({5'h00, ps[7:6], ps[2]}, 8'h00);
    op(5'b00001, 8'h07);
    chk({7'h00, ps[0]}, 8'h01);
    for (hold = 8'h00; hold < 8'h20; hold = hold + 8'h08) begin
      acc(1'b1, 8'hD0, hold, 1'b0, 3'h0);
      chk({3'h0, bank}, hold);
    end
    fork
      acc(1'b1, 8'h81, 8'h40, 1'b0, 3'h0);
      op(5'b10000, 8'h00);
    join
    chk(sp, 8'h40);
    acc(1'b1, 8'h87, 8'h01, 1'b0, 3'h0);
    wt(2'd0);
    repeat (8) @(posedge sys_clk);
    #1;
    chk(sp, 8'h40);
    chk(mo, 8'h07);
    @(posedge sys_clk);
    irq <= 1'b1;
    wt(2'd1);
    chk({7'h00, wake}, 8'h01);
    @(posedge sys_clk);
    irq <= 1'b0;
    wd_en <= 1'b1;
    // regular restarts keep the enabled watchdog from firing
    for (i = 0; i < 6; i = i + 1) begin
      repeat (9) @(posedge sys_clk);
      kick <= 1'b1;
      @(posedge sys_clk);
      kick <= 1'b0;
    end
    #1;
    chk(sp, 8'h40);
    acc(1'b1, 8'h87, 8'h01, 1'b0, 3'h0);
    wt(2'd2);
    @(posedge sys_clk);
    wd_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(sp, 8'h07);
    acc(1'b1, 8'h87, 8'h02, 1'b0, 3'h0);
    wt(2'd0);
    chk({7'h00, pstop}, 8'h01);
    chk({7'h00, ostop}, 8'h01);
    @(posedge sys_clk);
    irq <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk({7'h00, halt}, 8'h01);
    @(posedge sys_clk);
    {irq, cd_en, osc_ok} <= 3'b010;
    wt(2'd2);
    @(posedge sys_clk);
    {cd_en, osc_ok} <= 2'b01;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h00, pstop}, 8'h00);
    chk({7'h00, ostop}, 8'h00);
    acc(1'b1, 8'h87, 8'h01, 1'b0, 3'h0);
    wt(2'd0);
    @(posedge sys_clk);
    pin <= 1'b1;
    wt(2'd2);
    @(posedge sys_clk);
    pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({7'h00, halt}, 8'h00);
    tally_and_finish;
  end
endmodule
